// ### rtl/pcl_pkg.sv
// Package: constants, types and helpers for the parallel configuration loader
package pcl_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_NS = 25;
  localparam int unsigned STATUS_LOW_MIN_NS = 268000;
  localparam int unsigned POR_FAST_MIN_NS = 4000000;
  localparam int unsigned POR_STD_MIN_NS = 100000000;
  localparam int unsigned INIT_OSC_MIN_NS = 175000;
  // Four periods of the fastest allowed config clock (125 MHz)
  localparam int unsigned CFG_CLK_MAX_PERIOD_NS = 8;
  localparam int unsigned USER_CLK_DELAY_NS = 4 * CFG_CLK_MAX_PERIOD_NS;
  localparam int unsigned USER_INIT_CYCLES = 8576;

  // Least times round up to whole core cycles
  localparam int unsigned STATUS_LOW_CYC = (STATUS_LOW_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned POR_FAST_CYC = (POR_FAST_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned POR_STD_CYC = (POR_STD_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned INIT_OSC_CYC = (INIT_OSC_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [31:0] USER_CLK_DELAY_CYC = 32'((USER_CLK_DELAY_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // Strap settle time before the mode pins are captured
  localparam logic [31:0] STRAP_SETTLE_CYC = 32'h0000_0004;
  // Default image length in bytes
  localparam int unsigned LOAD_BYTES_DEF = 4096;

  // ----------------------------------------------------------------
  // Bus widths and option word layout
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  localparam int unsigned OPT_INIT_DONE_BIT = 0;
  localparam int unsigned OPT_USER_CLK_BIT = 1;
  localparam logic [2:0] FALL_EDGES_NEEDED = 3'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR, ST_HOLD_LOW, ST_RELEASE, ST_LOAD, ST_WAIT_FALLS, ST_INIT_DELAY, ST_INIT_USER, ST_USER
  } pcl_state_t;

  typedef struct packed {
    logic user_clk_en;
    logic init_done_en;
  } pcl_opts_t;

  // Link-side straps: arm, width, ratio
  typedef struct packed {
    logic arm;
    logic [1:0] width;
    logic [2:0] ratio;
  } pcl_link_in_t;

  // A change counts once second and third stage agree
  function automatic logic [5:0] pcl_agree(input logic [5:0] s2, input logic [5:0] s3, input logic [5:0] held);
    pcl_agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction : pcl_agree

  function automatic logic [2:0] pcl_bytes_per_word(input logic [1:0] width);
    case (width)
      WIDTH_HALF: pcl_bytes_per_word = 3'h2;
      WIDTH_WORD: pcl_bytes_per_word = 3'h4;
      default: pcl_bytes_per_word = 3'h1;
    endcase
  endfunction : pcl_bytes_per_word

endpackage : pcl_pkg

// ### rtl/pcl_loader.sv
// Fast passive parallel configuration loader: request handshake, data intake, init sequencing
// Summary of operation
// - User mode: all lines high; request low restarts
// - Status and load-complete low within 600 ns
// - Status low 268 us min, release promptly
// - Status held low for power-on delay
// - Mode pins pick fast or standard delay
// - Load-complete low until all data received
// - Data word sampled on config clock rise
// - Load-complete rises only after full image
// - Config clock ignored once configuration ends
// - Internal oscillator init: 175 us minimum
// - User clock init: delay, then 8576 cycles
// - Init-done driven low from load complete when option set
module pcl_loader
  import pcl_pkg::*;
#(
  parameter logic [31:0] LOAD_BYTES = 32'(LOAD_BYTES_DEF),
  parameter logic [31:0] STATUS_LOW_CYCLES = 32'(STATUS_LOW_CYC),
  parameter logic [31:0] POR_FAST_CYCLES = 32'(POR_FAST_CYC),
  parameter logic [31:0] POR_STD_CYCLES = 32'(POR_STD_CYC),
  parameter logic [31:0] INIT_OSC_CYCLES = 32'(INIT_OSC_CYC),
  parameter logic [31:0] USER_INIT_COUNT = 32'(USER_INIT_CYCLES)
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Host request and straps
  input wire logic CONFIG_REQUEST_N,
  input wire logic MODE_SELECT_FAST,
  input wire logic [1:0] BUS_WIDTH,
  input wire logic [2:0] CLOCK_DATA_RATIO,
  input wire logic USER_INIT_CLOCK,
  // Configuration link
  input wire logic CONFIG_CLOCK,
  input wire logic [31:0] CONFIG_DATA,
  // Open-drain status line
  input wire logic STATUS_N_IN,
  output logic STATUS_N_OUT,
  output logic STATUS_N_OE,
  // Completion and mode
  output logic LOAD_COMPLETE,
  output logic INIT_DONE_OUT,
  output logic INIT_DONE_OE,
  output logic USER_MODE
);

  // ----------------------------------------------------------------
  // Core-side input synchronisers
  // ----------------------------------------------------------------
  // Bits: 0 request, 1 mode, 2 status pin, 3 user clock, 4 done toggle, 5 init toggle
  logic [5:0] csync1_ff, csync2_ff, csync3_ff, cagree_ff;
  logic [5:0] core_raw, nxt_cagree;
  logic done_tgl_ff, init_tgl_ff;

  always_comb begin
    core_raw = {init_tgl_ff, done_tgl_ff, USER_INIT_CLOCK, STATUS_N_IN, MODE_SELECT_FAST, CONFIG_REQUEST_N};
    nxt_cagree = pcl_agree(csync2_ff, csync3_ff, cagree_ff);
  end

  always_ff @(posedge CORE_CLK) begin
    csync1_ff <= core_raw;
    csync2_ff <= csync1_ff;
    csync3_ff <= csync2_ff;
    if (RST) begin
      cagree_ff <= 6'h3F;
    end else begin
      cagree_ff <= nxt_cagree;
    end
  end

  logic req_n, mode_fast, status_pin, uclk, done_tgl_c, init_tgl_c;
  always_comb begin
    {init_tgl_c, done_tgl_c, uclk, status_pin, mode_fast, req_n} = cagree_ff;
  end

  // ----------------------------------------------------------------
  // Core sequencer
  // ----------------------------------------------------------------
  pcl_state_t state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  logic fast_ff, nxt_fast;
  logic arm_ff, nxt_arm;
  logic done_seen_ff, nxt_done_seen;
  logic init_seen_ff, nxt_init_seen;
  logic uclk_prev_ff, nxt_uclk_prev;
  logic status_oe_ff, nxt_status_oe;
  logic load_complete_ff, nxt_load_complete;
  logic init_done_oe_ff, nxt_init_done_oe;
  logic user_mode_ff, nxt_user_mode;
  pcl_opts_t opts_link;
  logic [31:0] por_cycles;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 32'h0000_0001;
    nxt_fast = fast_ff;
    nxt_arm = 1'b0;
    nxt_done_seen = done_tgl_c;
    nxt_init_seen = init_tgl_c;
    nxt_uclk_prev = uclk;
    nxt_status_oe = status_oe_ff;
    nxt_load_complete = load_complete_ff;
    nxt_init_done_oe = init_done_oe_ff;
    nxt_user_mode = user_mode_ff;
    por_cycles = fast_ff ? POR_FAST_CYCLES : POR_STD_CYCLES;
    case (state_ff)
      ST_POR: begin
        nxt_status_oe = 1'b1;
        if (cnt_ff == STRAP_SETTLE_CYC) begin
          nxt_fast = mode_fast;
        end
        if (cnt_ff >= por_cycles && cnt_ff > STRAP_SETTLE_CYC) begin
          nxt_state = ST_RELEASE;
          nxt_status_oe = 1'b0;
        end
      end
      ST_HOLD_LOW: begin
        // Minimum low time, then follow request
        if (cnt_ff >= STATUS_LOW_CYCLES && req_n) begin
          nxt_state = ST_RELEASE;
          nxt_status_oe = 1'b0;
        end
      end
      ST_RELEASE: begin
        // External hold on the status line delays loading
        if (status_pin) begin
          nxt_state = ST_LOAD;
          nxt_arm = 1'b1;
        end
      end
      ST_LOAD: begin
        nxt_arm = 1'b1;
        // Trailing falls may land before completion is seen; keep the old toggle
        nxt_init_seen = init_seen_ff;
        // Complete only on link's full-image toggle
        if (done_tgl_c != done_seen_ff) begin
          nxt_load_complete = 1'b1;
          nxt_init_done_oe = opts_link.init_done_en;
          nxt_state = ST_WAIT_FALLS;
        end
      end
      ST_WAIT_FALLS: begin
        nxt_arm = 1'b1;
        nxt_init_seen = init_seen_ff;
        nxt_cnt = 32'h0000_0000;
        if (init_tgl_c != init_seen_ff) begin
          nxt_state = opts_link.user_clk_en ? ST_INIT_USER : ST_INIT_DELAY;
        end
      end
      ST_INIT_DELAY: begin
        if (cnt_ff >= INIT_OSC_CYCLES) begin
          nxt_state = ST_USER;
        end
      end
      ST_INIT_USER: begin
        // Gate user clock after delay, count its edges
        nxt_cnt = cnt_ff;
        if (cnt_ff < USER_CLK_DELAY_CYC) begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end else if (uclk && !uclk_prev_ff) begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end
        if (cnt_ff >= USER_CLK_DELAY_CYC + USER_INIT_COUNT) begin
          nxt_state = ST_USER;
        end
      end
      ST_USER: begin
        nxt_user_mode = 1'b1;
        nxt_init_done_oe = 1'b0;
      end
      default: begin
        nxt_state = ST_POR;
      end
    endcase
    if (state_ff == ST_INIT_DELAY && cnt_ff >= INIT_OSC_CYCLES) begin
      nxt_user_mode = 1'b1;
      nxt_init_done_oe = 1'b0;
    end
    if (state_ff == ST_INIT_USER && cnt_ff >= USER_CLK_DELAY_CYC + USER_INIT_COUNT) begin
      nxt_user_mode = 1'b1;
      nxt_init_done_oe = 1'b0;
    end
    // Request low restarts from any loaded state
    // Status and load-complete drop within a few cycles
    if (!req_n && state_ff != ST_POR) begin
      nxt_state = ST_HOLD_LOW;
      nxt_cnt = 32'h0000_0000;
      nxt_arm = 1'b0;
      nxt_status_oe = 1'b1;
      nxt_load_complete = 1'b0;
      nxt_init_done_oe = 1'b0;
      nxt_user_mode = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_ff <= ST_POR;
      cnt_ff <= 32'h0000_0000;
      fast_ff <= 1'b0;
      arm_ff <= 1'b0;
      done_seen_ff <= 1'b0;
      init_seen_ff <= 1'b0;
      uclk_prev_ff <= 1'b0;
      status_oe_ff <= 1'b1;
      load_complete_ff <= 1'b0;
      init_done_oe_ff <= 1'b0;
      user_mode_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      fast_ff <= nxt_fast;
      arm_ff <= nxt_arm;
      done_seen_ff <= nxt_done_seen;
      init_seen_ff <= nxt_init_seen;
      uclk_prev_ff <= nxt_uclk_prev;
      status_oe_ff <= nxt_status_oe;
      load_complete_ff <= nxt_load_complete;
      init_done_oe_ff <= nxt_init_done_oe;
      user_mode_ff <= nxt_user_mode;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge CORE_CLK) begin
    STATUS_N_OUT <= 1'b0;
    INIT_DONE_OUT <= 1'b0;
  end

  always_comb begin
    STATUS_N_OE = status_oe_ff;
    LOAD_COMPLETE = load_complete_ff;
    INIT_DONE_OE = init_done_oe_ff;
    USER_MODE = user_mode_ff;
  end

  // ----------------------------------------------------------------
  // Link-side synchronisers
  // ----------------------------------------------------------------
  // Core reset is carried over too, so the link toggles start defined
  logic [5:0] lsync1_ff, lsync2_ff, lsync3_ff, lagree_ff;
  logic [5:0] nxt_lagree;
  logic lrst1_ff, lrst2_ff, lrst3_ff;
  pcl_link_in_t link_in;

  always_comb begin
    nxt_lagree = pcl_agree(lsync2_ff, lsync3_ff, lagree_ff);
    link_in = lagree_ff;
  end

  always_ff @(posedge CONFIG_CLOCK) begin
    lsync1_ff <= {arm_ff, BUS_WIDTH, CLOCK_DATA_RATIO};
    lsync2_ff <= lsync1_ff;
    lsync3_ff <= lsync2_ff;
    lrst1_ff <= RST;
    lrst2_ff <= lrst1_ff;
    lrst3_ff <= lrst2_ff;
    if (lrst3_ff) begin
      lagree_ff <= 6'h00;
    end else begin
      lagree_ff <= nxt_lagree;
    end
  end

  // ----------------------------------------------------------------
  // Link data intake (rising edge)
  // ----------------------------------------------------------------
  logic [31:0] byte_cnt_ff, nxt_byte_cnt;
  logic [2:0] ratio_cnt_ff, nxt_ratio_cnt;
  logic first_ff, nxt_first;
  logic link_done_ff, nxt_link_done;
  logic nxt_done_tgl;
  pcl_opts_t opts_ff, nxt_opts;
  logic [2:0] last_phase;

  always_comb begin
    nxt_byte_cnt = byte_cnt_ff;
    nxt_ratio_cnt = ratio_cnt_ff;
    nxt_first = first_ff;
    nxt_link_done = link_done_ff;
    nxt_done_tgl = done_tgl_ff;
    nxt_opts = opts_ff;
    last_phase = (link_in.ratio == 3'h0) ? 3'h0 : link_in.ratio - 3'h1;
    // Disarmed: clock ignored, partial load dropped
    if (!link_in.arm) begin
      nxt_byte_cnt = 32'h0000_0000;
      nxt_ratio_cnt = 3'h0;
      nxt_first = 1'b1;
      nxt_link_done = 1'b0;
    end else if (!link_done_ff) begin
      nxt_ratio_cnt = (ratio_cnt_ff >= last_phase) ? 3'h0 : ratio_cnt_ff + 3'h1;
      // Word taken on the first rise of each ratio group
      if (ratio_cnt_ff == 3'h0) begin
        nxt_byte_cnt = byte_cnt_ff + {29'h0, pcl_bytes_per_word(link_in.width)};
        nxt_first = 1'b0;
        if (first_ff) begin
          nxt_opts.init_done_en = CONFIG_DATA[OPT_INIT_DONE_BIT];
          nxt_opts.user_clk_en = CONFIG_DATA[OPT_USER_CLK_BIT];
        end
        // Done only once the whole image is in
        if (byte_cnt_ff + {29'h0, pcl_bytes_per_word(link_in.width)} >= LOAD_BYTES) begin
          nxt_link_done = 1'b1;
          nxt_done_tgl = ~done_tgl_ff;
        end
      end
    end
  end

  always_ff @(posedge CONFIG_CLOCK) begin
    if (lrst3_ff) begin
      byte_cnt_ff <= 32'h0000_0000;
      ratio_cnt_ff <= 3'h0;
      first_ff <= 1'b1;
      link_done_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      opts_ff <= '0;
    end else begin
      byte_cnt_ff <= nxt_byte_cnt;
      ratio_cnt_ff <= nxt_ratio_cnt;
      first_ff <= nxt_first;
      link_done_ff <= nxt_link_done;
      done_tgl_ff <= nxt_done_tgl;
      opts_ff <= nxt_opts;
    end
  end

  // Options are stable well before the done toggle reaches the core
  always_comb begin
    opts_link = opts_ff;
  end

  // ----------------------------------------------------------------
  // Trailing falling edges
  // ----------------------------------------------------------------
  logic [2:0] fall_cnt_ff, nxt_fall_cnt;
  logic nxt_init_tgl;

  always_comb begin
    nxt_fall_cnt = fall_cnt_ff;
    nxt_init_tgl = init_tgl_ff;
    if (!link_in.arm || !link_done_ff) begin
      nxt_fall_cnt = 3'h0;
    end else if (fall_cnt_ff < FALL_EDGES_NEEDED) begin
      nxt_fall_cnt = fall_cnt_ff + 3'h1;
      // Second fall after completion starts initialization
      if (fall_cnt_ff + 3'h1 == FALL_EDGES_NEEDED) begin
        nxt_init_tgl = ~init_tgl_ff;
      end
    end
  end

  always_ff @(negedge CONFIG_CLOCK) begin
    if (lrst3_ff) begin
      fall_cnt_ff <= 3'h0;
      init_tgl_ff <= 1'b0;
    end else begin
      fall_cnt_ff <= nxt_fall_cnt;
      init_tgl_ff <= nxt_init_tgl;
    end
  end

endmodule : pcl_loader

// ### verification/pcl_loader_properties.sv
// Checker: port-level timing properties of the configuration loader
module pcl_loader_checker
  import pcl_pkg::*;
#(
  parameter logic [31:0] STATUS_LOW_CYCLES = 32'h14,
  parameter logic [31:0] POR_FAST_CYCLES = 32'h28,
  parameter logic [31:0] POR_STD_CYCLES = 32'h3C,
  parameter logic [31:0] INIT_OSC_CYCLES = 32'h1E,
  parameter logic [31:0] USER_INIT_COUNT = 32'h8
) (
  // Clock and host side
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CONFIG_REQUEST_N,
  input wire logic MODE_SELECT_FAST,
  input wire logic USER_INIT_CLOCK,
  // Device side
  input wire logic STATUS_N_OUT,
  input wire logic STATUS_N_OE,
  input wire logic LOAD_COMPLETE,
  input wire logic INIT_DONE_OUT,
  input wire logic INIT_DONE_OE,
  input wire logic USER_MODE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] oe_cnt_ff, lc_cnt_ff, uc_cnt_ff, rq_cnt_ff;
  logic por_done_ff, uc_prev_ff;
  // ----
  // Helper counters: raw user clock rises overcount the synced ones
  // ----
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      oe_cnt_ff <= 32'h0;
      lc_cnt_ff <= 32'h0;
      uc_cnt_ff <= 32'h0;
      rq_cnt_ff <= 32'h0;
      por_done_ff <= 1'b0;
      uc_prev_ff <= 1'b0;
    end else begin
      oe_cnt_ff <= STATUS_N_OE ? oe_cnt_ff + 32'h1 : 32'h0;
      lc_cnt_ff <= (LOAD_COMPLETE && !USER_MODE) ? lc_cnt_ff + 32'h1 : 32'h0;
      uc_cnt_ff <= (LOAD_COMPLETE && !USER_MODE) ? uc_cnt_ff + {31'h0, USER_INIT_CLOCK & ~uc_prev_ff} : 32'h0;
      uc_prev_ff <= USER_INIT_CLOCK;
      // Release deadline runs from the raw request rise
      rq_cnt_ff <= CONFIG_REQUEST_N ? rq_cnt_ff + 32'h1 : 32'h0;
      por_done_ff <= por_done_ff | ~STATUS_N_OE;
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_req_answer: assert property (
    $fell(CONFIG_REQUEST_N) && por_done_ff |-> ##[1:24] (STATUS_N_OE && !LOAD_COMPLETE && !USER_MODE))
    else $error("request fall not answered in time");
  chk_status_min: assert property (
    $fell(STATUS_N_OE) |-> oe_cnt_ff >= STATUS_LOW_CYCLES)
    else $error("status released too early");
  chk_status_release: assert property (
    por_done_ff && rq_cnt_ff == STATUS_LOW_CYCLES + 32'h8 |-> !STATUS_N_OE)
    else $error("status held low too long");
  chk_por_min: assert property (
    !por_done_ff && $fell(STATUS_N_OE) |-> oe_cnt_ff >= (MODE_SELECT_FAST ? POR_FAST_CYCLES : POR_STD_CYCLES))
    else $error("power-on delay too short");
  chk_por_max: assert property (
    !por_done_ff && $fell(STATUS_N_OE) |-> oe_cnt_ff <= (MODE_SELECT_FAST ? POR_FAST_CYCLES : POR_STD_CYCLES) + 16)
    else $error("power-on delay too long");
  chk_done_low: assert property (
    STATUS_N_OE |-> !STATUS_N_OUT && !LOAD_COMPLETE)
    else $error("completion high while status low");
  chk_user_lines: assert property (
    USER_MODE |-> LOAD_COMPLETE && !STATUS_N_OE && !INIT_DONE_OE)
    else $error("user mode with a line low");
  chk_init_time: assert property (
    $rose(USER_MODE) |-> lc_cnt_ff >= INIT_OSC_CYCLES || uc_cnt_ff >= USER_INIT_COUNT)
    else $error("user mode entered too soon");
  chk_init_drive: assert property (
    INIT_DONE_OE |-> !INIT_DONE_OUT && !USER_MODE)
    else $error("init-done driven wrongly");
  chk_restart: assert property (
    (por_done_ff && !CONFIG_REQUEST_N)[*8] |-> !LOAD_COMPLETE && !USER_MODE)
    else $error("request low did not restart");
endmodule : pcl_loader_checker

bind pcl_loader pcl_loader_checker #(.STATUS_LOW_CYCLES(STATUS_LOW_CYCLES), .POR_FAST_CYCLES(POR_FAST_CYCLES),
  .POR_STD_CYCLES(POR_STD_CYCLES), .INIT_OSC_CYCLES(INIT_OSC_CYCLES), .USER_INIT_COUNT(USER_INIT_COUNT)) i_chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .CONFIG_REQUEST_N(CONFIG_REQUEST_N), .MODE_SELECT_FAST(MODE_SELECT_FAST),
  .USER_INIT_CLOCK(USER_INIT_CLOCK), .STATUS_N_OUT(STATUS_N_OUT), .STATUS_N_OE(STATUS_N_OE),
  .LOAD_COMPLETE(LOAD_COMPLETE), .INIT_DONE_OUT(INIT_DONE_OUT), .INIT_DONE_OE(INIT_DONE_OE), .USER_MODE(USER_MODE));

// ### verification/pcl_host_model.sv
// Host model: configuration controller driving request, link clock and data
module pcl_host_model
  import pcl_pkg::*;
(
  // Core clock paces the request line
  input wire logic clk,
  input wire logic status_n,
  // Toward the loader
  output logic config_request_n,
  output logic config_clock,
  output logic [31:0] config_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // 2 us at the 25 ns core period
  localparam int REQ_LOW_CYC = 80;
  initial begin
    config_request_n = 1'b1;
    config_clock = 1'b0;
    config_data = 32'h0;
  end
  task automatic pulse_n(input int n);
    repeat (n) begin
      // 32 ns period, rise samples data
      #16 config_clock = 1'b1;
      #16 config_clock = 1'b0;
    end
  endtask : pulse_n
  task automatic reconfigure(output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    config_request_n = 1'b0;
    // Link only sees the disarm with its clock running; partial load dropped here
    repeat (10) @(negedge clk);
    pulse_n(6);
    repeat (REQ_LOW_CYC) @(negedge clk);
    config_request_n = 1'b1;
    while (status_n !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    ok = (status_n === 1'b1);
    // first rise 2 us after status high
    #2000;
    // Four idle edges carry the arm across; data follows from the fifth
    pulse_n(4);
  endtask : reconfigure
  task automatic send_word(input logic [31:0] d, input logic [2:0] r);
    // new word set up while the clock sits low
    config_data = d;
    // word held across all N periods
    pulse_n((r < 3'h2) ? 1 : int'(r));
  endtask : send_word
  task automatic finish_frame();
    pulse_n(2);
    // clock parked low; released data no longer valid
    config_data = ~config_data;
  endtask : finish_frame
endmodule : pcl_host_model

// ### verification/pcl_loader_bench.sv
// Testbench: power-on delays, loads over each width at ratios 1 to 4, aborted load
module pcl_loader_bench
  import pcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] LB = 32'h10;
  localparam int POR_F = 40;
  localparam int POR_S = 60;
  logic core_clk, rst, mode_fast, user_clk, config_request_n, config_clock, status_n;
  logic [1:0] bus_width;
  logic [2:0] ratio;
  logic [31:0] config_data, seed;
  logic status_n_out, status_n_oe, load_complete, init_done_out, init_done_oe, user_mode;
  int errors, total_checks;
  // Open-drain status line with pull-up
  assign status_n = status_n_oe ? status_n_out : 1'b1;
  always #12.5 core_clk = ~core_clk;
  pcl_loader #(.LOAD_BYTES(LB), .STATUS_LOW_CYCLES(32'h14), .POR_FAST_CYCLES(32'(POR_F)),
    .POR_STD_CYCLES(32'(POR_S)), .INIT_OSC_CYCLES(32'h1E), .USER_INIT_COUNT(32'h8)) i_dut (
    .CORE_CLK(core_clk), .RST(rst), .CONFIG_REQUEST_N(config_request_n), .MODE_SELECT_FAST(mode_fast),
    .BUS_WIDTH(bus_width), .CLOCK_DATA_RATIO(ratio), .USER_INIT_CLOCK(user_clk), .CONFIG_CLOCK(config_clock),
    .CONFIG_DATA(config_data), .STATUS_N_IN(status_n), .STATUS_N_OUT(status_n_out), .STATUS_N_OE(status_n_oe),
    .LOAD_COMPLETE(load_complete), .INIT_DONE_OUT(init_done_out), .INIT_DONE_OE(init_done_oe), .USER_MODE(user_mode));
  pcl_host_model i_host (.clk(core_clk), .status_n(status_n), .config_request_n(config_request_n),
    .config_clock(config_clock), .config_data(config_data));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic int bytes_for(input logic [1:0] w);
    return (w == WIDTH_HALF) ? 2 : (w == WIDTH_WORD) ? 4 : 1;
  endfunction : bytes_for
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic wait_high(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (sig !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      finish_test();
    end
  endtask : wait_high
  task automatic do_reset(input logic fast, input int por);
    int n;
    n = 0;
    @(negedge core_clk);
    mode_fast = fast;
    rst = 1'b1;
    // Link reset only completes with the link clock running
    fork
      repeat (10) @(negedge core_clk);
      i_host.pulse_n(6);
    join
    rst = 1'b0;
    while (status_n_oe === 1'b1 && n < 200) begin
      check(load_complete, 0);
      @(negedge core_clk);
      n++;
    end
    check(n >= por && n <= por + 16, 1);
  endtask : do_reset
  task automatic run_load(input logic [1:0] w, input logic [2:0] r, input logic [31:0] opts, input bit cut);
    bit ok;
    int words;
    words = int'(LB) / bytes_for(w);
    @(negedge core_clk);
    bus_width = w;
    ratio = r;
    i_host.reconfigure(ok);
    check(ok, 1);
    if (cut) begin
      repeat (words / 2) i_host.send_word(rnd(), r);
      i_host.reconfigure(ok);
      check(ok, 1);
    end
    for (int i = 0; i < words; i++) begin
      if (i == words - 1) begin
        // Clock paused low before the last word
        repeat (8) @(negedge core_clk);
        check(load_complete, 0);
      end
      i_host.send_word((i == 0) ? opts : rnd(), r);
    end
    wait_high(load_complete, 20);
    @(negedge core_clk);
    check(init_done_oe, opts[OPT_INIT_DONE_BIT]);
    i_host.finish_frame();
    wait_high(user_mode, 600);
    check({user_mode, status_n, load_complete, init_done_oe}, 4'hE);
    i_host.pulse_n(3);
    check(user_mode, 1);
  endtask : run_load
  initial begin
    user_clk = 1'b0;
    #6;
    forever #200 user_clk = ~user_clk;
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    mode_fast = 1'b1;
    bus_width = WIDTH_BYTE;
    ratio = 3'h1;
    seed = 32'h4A30794F;
    errors = 0;
    total_checks = 0;
    do_reset(1'b1, POR_F);
    run_load(WIDTH_BYTE, 3'h1, 32'h0000_0003, 1'b0);
    for (int k = 0; k < 3; k++) run_load(2'(k), 3'(rnd() % 4) + 3'h1, rnd(), k == 1);
    do_reset(1'b0, POR_S);
    run_load(WIDTH_WORD, 3'h4, 32'h0000_0000, 1'b1);
    finish_test();
  end
  initial begin
    #1000000;
    errors++;
    finish_test();
  end
endmodule : pcl_loader_bench
